// [srcfg_top.sv]
// Purpose: readout configuration bank with row and frame sequencing
// Assumes: byte register port, reads answer one cycle later
// Notes: settings are used live; change them between frames only
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module srcfg_top
    import srcfg_pkg::*;
#(
    parameter int ROW_CYCLES = 4
)(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire srcfg_bus_type bus_in,
    input wire logic frame_req_in,
    input wire logic internal_exposure_in,
    input wire logic bit_mode_10_in,
    input wire logic [ROW_W-1:0] row_base_in,
    input wire logic [PIX_W-1:0] pixel_data_in,
    output logic [DATA_W-1:0] rdata_out,
    output logic [ROW_W-1:0] row_addr_out,
    output logic row_strobe_out,
    output logic data_valid_out,
    output logic [PIX_W-1:0] lane_word_out,
    output logic [LANES_MAX-1:0] lane_enable_out,
    output logic frame_start_out,
    output logic burst_done_out,
    output logic busy_out,
    output srcfg_synth_type synth_out
);
    localparam int TMR_W = $clog2(ROW_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(ROW_CYCLES - 1);

    typedef struct packed {
        logic [15:0] total_row_count;
        logic [15:0] plain_row_skip;
        logic [15:0] pair_row_skip;
        logic [15:0] frame_burst_count;
        logic [1:0] lane_count_select;
        logic [3:0] rx_bias_level;
        logic [11:0] idle_word;
        logic ext_serial_clock_enable;
        logic synth_on;
        logic [1:0] synth_in_band;
        logic synth_skip;
        logic [7:0] synth_band_select;
        logic [DATA_W-1:0] rdata;
        srcfg_seq_type seq;
        logic req_seen;
        logic [15:0] rows_left;
        logic [15:0] frames_left;
        logic [ROW_W-1:0] row_offset;
        logic [TMR_W-1:0] tmr;
        logic [ROW_W-1:0] row_addr;
        logic row_strobe;
        logic data_valid;
        logic [PIX_W-1:0] lane_word;
        logic [LANES_MAX-1:0] lane_enable;
        logic frame_start;
        logic burst_done;
        logic busy;
        srcfg_synth_type synth;
    } srcfg_state_type;

    srcfg_state_type state_reg;
    srcfg_state_type state_next;
    logic req_level;
    logic [LANES_MAX-1:0] lane_mask;
    logic [1:0] lane_sel;
    logic [15:0] skip_sum;
    logic [PIX_W-1:0] idle_shown;

    srcfg_sync srcfg_sync_inst (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .pin_in(frame_req_in),
        .level_out(req_level)
    );

    // select write reaches the enables on the next edge, like the settings fed to synth_out
    assign lane_sel = (bus_in.wr && (bus_in.addr == ADR_LANES))
        ? bus_in.wdata[1:0] : state_reg.lane_count_select;

    // lane i is live when it lies below 16 >> select
    for (genvar i = 0; i < LANES_MAX; i++) begin : g_lane
        assign lane_mask[i] = (i < (LANES_MAX >> lane_sel));
    end

    // plain and paired counts add: in advanced use plain stays zero
    assign skip_sum = state_reg.plain_row_skip + state_reg.pair_row_skip;

    // 10-bit mode drops the upper two bits of the idle word
    always_comb begin
        idle_shown = state_reg.idle_word;
        if (bit_mode_10_in) begin
            idle_shown = {{(PIX_W-NARROW_W){1'b0}}, state_reg.idle_word[NARROW_W-1:0]};
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.row_strobe = 1'b0;
        state_next.frame_start = 1'b0;
        state_next.burst_done = 1'b0;
        state_next.req_seen = req_level;

        // register writes, low byte at lower address
        if (bus_in.wr) begin
            case (bus_in.addr)
                ADR_ROWS_LO: begin
                    state_next.total_row_count[7:0] = bus_in.wdata;
                end
                ADR_ROWS_HI: begin
                    state_next.total_row_count[15:8] = bus_in.wdata;
                end
                ADR_PLAIN_LO: begin
                    state_next.plain_row_skip[7:0] = bus_in.wdata;
                end
                ADR_PLAIN_HI: begin
                    state_next.plain_row_skip[15:8] = bus_in.wdata;
                end
                ADR_PAIR_LO: begin
                    state_next.pair_row_skip[7:0] = bus_in.wdata;
                end
                ADR_PAIR_HI: begin
                    state_next.pair_row_skip[15:8] = bus_in.wdata;
                end
                ADR_FRAMES_LO: begin
                    state_next.frame_burst_count[7:0] = bus_in.wdata;
                end
                ADR_FRAMES_HI: begin
                    state_next.frame_burst_count[15:8] = bus_in.wdata;
                end
                ADR_LANES: begin
                    state_next.lane_count_select = bus_in.wdata[1:0];
                end
                ADR_RX_BIAS: begin
                    state_next.rx_bias_level = bus_in.wdata[3:0];
                end
                ADR_IDLE_LO: begin
                    state_next.idle_word[7:0] = bus_in.wdata;
                end
                ADR_IDLE_HI: begin
                    state_next.idle_word[11:8] = bus_in.wdata[IDLE_HI_W-1:0];
                end
                ADR_CLK_IN: begin
                    state_next.ext_serial_clock_enable = bus_in.wdata[EXT_CLK_BIT];
                end
                ADR_SYN_ON: begin
                    state_next.synth_on = bus_in.wdata[0];
                end
                ADR_SYN_IN: begin
                    state_next.synth_in_band = bus_in.wdata[1:0];
                end
                ADR_SYN_SKIP: begin
                    state_next.synth_skip = bus_in.wdata[0];
                end
                ADR_SYN_BAND: begin
                    state_next.synth_band_select = bus_in.wdata;
                end
                default: begin
                end
            endcase
        end

        // read data valid only in the cycle after the strobe
        state_next.rdata = '0;
        if (bus_in.rd) begin
            case (bus_in.addr)
                ADR_ROWS_LO: begin
                    state_next.rdata = state_reg.total_row_count[7:0];
                end
                ADR_ROWS_HI: begin
                    state_next.rdata = state_reg.total_row_count[15:8];
                end
                ADR_PLAIN_LO: begin
                    state_next.rdata = state_reg.plain_row_skip[7:0];
                end
                ADR_PLAIN_HI: begin
                    state_next.rdata = state_reg.plain_row_skip[15:8];
                end
                ADR_PAIR_LO: begin
                    state_next.rdata = state_reg.pair_row_skip[7:0];
                end
                ADR_PAIR_HI: begin
                    state_next.rdata = state_reg.pair_row_skip[15:8];
                end
                ADR_FRAMES_LO: begin
                    state_next.rdata = state_reg.frame_burst_count[7:0];
                end
                ADR_FRAMES_HI: begin
                    state_next.rdata = state_reg.frame_burst_count[15:8];
                end
                ADR_LANES: begin
                    state_next.rdata = {6'h00, state_reg.lane_count_select};
                end
                ADR_RX_BIAS: begin
                    state_next.rdata = {4'h0, state_reg.rx_bias_level};
                end
                ADR_IDLE_LO: begin
                    state_next.rdata = state_reg.idle_word[7:0];
                end
                ADR_IDLE_HI: begin
                    state_next.rdata = {4'h0, state_reg.idle_word[11:8]};
                end
                ADR_CLK_IN: begin
                    state_next.rdata = '0;
                    state_next.rdata[EXT_CLK_BIT] = state_reg.ext_serial_clock_enable;
                end
                ADR_SYN_ON: begin
                    state_next.rdata = {7'h00, state_reg.synth_on};
                end
                ADR_SYN_IN: begin
                    state_next.rdata = {6'h00, state_reg.synth_in_band};
                end
                ADR_SYN_SKIP: begin
                    state_next.rdata = {7'h00, state_reg.synth_skip};
                end
                ADR_SYN_BAND: begin
                    state_next.rdata = state_reg.synth_band_select;
                end
                default: begin
                    state_next.rdata = '0;
                end
            endcase
        end

        // row and frame sequencing
        case (state_reg.seq)
            SEQ_IDLE: begin
                state_next.busy = 1'b0;
                if (req_level && !state_reg.req_seen) begin
                    // external exposure gives one frame per request
                    state_next.frames_left = 16'h0001;
                    if (internal_exposure_in && (state_reg.frame_burst_count != '0)) begin
                        state_next.frames_left = state_reg.frame_burst_count;
                    end
                    state_next.rows_left = state_reg.total_row_count;
                    state_next.row_offset = '0;
                    state_next.row_addr = row_base_in;
                    state_next.tmr = '0;
                    state_next.frame_start = 1'b1;
                    state_next.row_strobe = 1'b1;
                    state_next.busy = 1'b1;
                    state_next.seq = SEQ_ROW;
                end
            end
            SEQ_ROW: begin
                if (state_reg.tmr == TMR_LAST) begin
                    state_next.seq = SEQ_STEP;
                end else begin
                    state_next.tmr = state_reg.tmr + TMR_W'(1);
                end
            end
            SEQ_STEP: begin
                state_next.tmr = '0;
                // a zero count is treated as one row so the frame ends
                if (state_reg.rows_left <= 16'h0001) begin
                    state_next.seq = SEQ_END;
                end else begin
                    state_next.rows_left = state_reg.rows_left - 16'h0001;
                    state_next.row_offset = state_reg.row_offset
                        + ROW_W'(skip_sum) + ROW_W'(1);
                    state_next.row_addr = row_base_in + state_reg.row_offset
                        + ROW_W'(skip_sum) + ROW_W'(1);
                    state_next.row_strobe = 1'b1;
                    state_next.seq = SEQ_ROW;
                end
            end
            SEQ_END: begin
                if (state_reg.frames_left <= 16'h0001) begin
                    state_next.burst_done = 1'b1;
                    state_next.busy = 1'b0;
                    state_next.seq = SEQ_IDLE;
                end else begin
                    state_next.frames_left = state_reg.frames_left - 16'h0001;
                    state_next.rows_left = state_reg.total_row_count;
                    state_next.row_offset = '0;
                    state_next.row_addr = row_base_in;
                    state_next.frame_start = 1'b1;
                    state_next.row_strobe = 1'b1;
                    state_next.seq = SEQ_ROW;
                end
            end
            default: begin
                state_next.seq = SEQ_IDLE;
            end
        endcase

        // lane data: pixels during a row, idle word otherwise
        state_next.data_valid = (state_next.seq == SEQ_ROW);
        if (state_next.seq == SEQ_ROW) begin
            state_next.lane_word = pixel_data_in;
            if (bit_mode_10_in) begin
                state_next.lane_word[PIX_W-1:NARROW_W] = '0;
            end
        end else begin
            state_next.lane_word = idle_shown;
        end
        state_next.lane_enable = lane_mask;

        // clock multiplier controls; internal source unless bypassed or off
        state_next.synth.mult_on = state_next.synth_on;
        state_next.synth.mult_bypass = state_next.synth_skip;
        state_next.synth.use_internal = state_next.synth_on
            && !state_next.synth_skip;
        state_next.synth.ext_clk_en = state_next.ext_serial_clock_enable;
        state_next.synth.rx_bias = state_next.rx_bias_level;
        state_next.synth.rx_current_on = (state_next.rx_bias_level != '0);
        state_next.synth.in_band = state_next.synth_in_band;
        state_next.synth.out_band =
            state_next.synth_band_select[OUT_BAND_LSB +: OUT_BAND_W];
        state_next.synth.range = state_next.synth_band_select[RANGE_BIT];
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= '0;
            state_reg.total_row_count <= ROWS_RST;
            state_reg.plain_row_skip <= SKIP_RST;
            state_reg.pair_row_skip <= SKIP_RST;
            state_reg.frame_burst_count <= FRAMES_RST;
            state_reg.lane_count_select <= LANES_RST;
            state_reg.rx_bias_level <= RX_BIAS_RST;
            state_reg.idle_word <= IDLE_RST;
            state_reg.ext_serial_clock_enable <= EXT_CLK_RST;
            state_reg.synth_on <= SYN_ON_RST;
            state_reg.synth_in_band <= SYN_IN_RST;
            state_reg.synth_skip <= SYN_SKIP_RST;
            state_reg.synth_band_select <= SYN_BAND_RST;
            state_reg.seq <= SEQ_IDLE;
            state_reg.lane_word <= IDLE_RST;
            state_reg.lane_enable <= '1;
            state_reg.synth.mult_on <= SYN_ON_RST;
            state_reg.synth.use_internal <= 1'b1;
            state_reg.synth.rx_bias <= RX_BIAS_RST;
            state_reg.synth.rx_current_on <= 1'b1;
            state_reg.synth.out_band <= SYN_BAND_RST[OUT_BAND_LSB +: OUT_BAND_W];
            state_reg.synth.range <= SYN_BAND_RST[RANGE_BIT];
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_out = state_reg.rdata;
    assign row_addr_out = state_reg.row_addr;
    assign row_strobe_out = state_reg.row_strobe;
    assign data_valid_out = state_reg.data_valid;
    assign lane_word_out = state_reg.lane_word;
    assign lane_enable_out = state_reg.lane_enable;
    assign frame_start_out = state_reg.frame_start;
    assign burst_done_out = state_reg.burst_done;
    assign busy_out = state_reg.busy;
    assign synth_out = state_reg.synth;
endmodule

// [srcfg_pkg.sv]
// Purpose: constants, types and state layouts of the readout configuration bank
// Assumes: byte-wide register port, one clock at 40 MHz
// Notes: every multi-byte setting is little endian across byte addresses
//
// Overview of operation
// - simple mode skips the plain skip count of rows; pair skip acts alike.
// - subsampling combines with any window base from the windowing logic.
// - the programmed total row count is read out, one row for a zero count; reset 1088.
// - internal exposure: each request yields the programmed frame count, one frame for zero; reset 1.
// - lane select 0..3 enables sixteen, eight, four or two lanes.
// - idle word goes out on active lanes whenever no valid image data.
// - idle word sends 12 low bits, or 10 in 10-bit mode; reset 85.
// - serial clock comes from the internal multiplier by default.
// - synth-on bit gates the multiplier; synth-skip bit bypasses it.
// - bias field zero turns receiver current off; 1..15 raise it; reset 8.
package srcfg_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int ROW_W = 11;
    localparam int PIX_W = 12;
    localparam int LANES_MAX = 16;
    localparam logic [ADDR_W-1:0] ADR_ROWS_LO = 7'h01;
    localparam logic [ADDR_W-1:0] ADR_ROWS_HI = 7'h02;
    localparam logic [ADDR_W-1:0] ADR_PLAIN_LO = 7'h23;
    localparam logic [ADDR_W-1:0] ADR_PLAIN_HI = 7'h24;
    localparam logic [ADDR_W-1:0] ADR_PAIR_LO = 7'h25;
    localparam logic [ADDR_W-1:0] ADR_PAIR_HI = 7'h26;
    localparam logic [ADDR_W-1:0] ADR_FRAMES_LO = 7'h46;
    localparam logic [ADDR_W-1:0] ADR_FRAMES_HI = 7'h47;
    localparam logic [ADDR_W-1:0] ADR_LANES = 7'h48;
    localparam logic [ADDR_W-1:0] ADR_RX_BIAS = 7'h4a;
    localparam logic [ADDR_W-1:0] ADR_IDLE_LO = 7'h4e;
    localparam logic [ADDR_W-1:0] ADR_IDLE_HI = 7'h4f;
    localparam logic [ADDR_W-1:0] ADR_CLK_IN = 7'h52;
    localparam logic [ADDR_W-1:0] ADR_SYN_ON = 7'h71;
    localparam logic [ADDR_W-1:0] ADR_SYN_IN = 7'h72;
    localparam logic [ADDR_W-1:0] ADR_SYN_SKIP = 7'h73;
    localparam logic [ADDR_W-1:0] ADR_SYN_BAND = 7'h74;
    localparam logic [15:0] ROWS_RST = 16'h0440;
    localparam logic [15:0] FRAMES_RST = 16'h0001;
    localparam logic [15:0] SKIP_RST = 16'h0000;
    localparam logic [1:0] LANES_RST = 2'h0;
    localparam logic [3:0] RX_BIAS_RST = 4'h8;
    localparam logic [11:0] IDLE_RST = 12'h055;
    localparam logic EXT_CLK_RST = 1'b0;
    localparam logic SYN_ON_RST = 1'b1;
    localparam logic SYN_SKIP_RST = 1'b0;
    localparam logic [1:0] SYN_IN_RST = 2'h0;
    localparam logic [7:0] SYN_BAND_RST = 8'hd9;
    localparam int EXT_CLK_BIT = 2;
    localparam int RANGE_BIT = 7;
    localparam int OUT_BAND_LSB = 4;
    localparam int OUT_BAND_W = 3;
    localparam int IDLE_HI_W = 4;
    localparam int NARROW_W = 10;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } srcfg_bus_type;

    typedef struct packed {
        logic mult_on;
        logic mult_bypass;
        logic use_internal;
        logic ext_clk_en;
        logic rx_current_on;
        logic [3:0] rx_bias;
        logic [1:0] in_band;
        logic [2:0] out_band;
        logic range;
    } srcfg_synth_type;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_ROW = 4'b0010,
        SEQ_STEP = 4'b0100,
        SEQ_END = 4'b1000
    } srcfg_seq_type;

    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } srcfg_sync_type;
endpackage

// [srcfg_sync.sv]
// Purpose: three-flop synchroniser for a pin level
// Assumes: input is asynchronous to clk_in
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ps
module srcfg_sync
    import srcfg_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic pin_in,
    output logic level_out
);
    srcfg_sync_type state_reg;
    srcfg_sync_type state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage = {state_reg.stage[1:0], pin_in};
        // stage 0 feeds only stage 1; filter looks at later stages
        if (state_reg.stage[1] == state_reg.stage[2]) begin
            state_next.level = state_reg.stage[2];
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.level;
endmodule

// [srcfg_chk.sv]
// Purpose: port-level checks of the readout configuration bank
// Assumes: one clock, async active-low reset
// Notes: row length checked against ROW_CYCLES by a counter
`timescale 1ns/1ps
module srcfg_chk
    import srcfg_pkg::*;
#(
    parameter int ROW_CYCLES = 4
)(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire srcfg_bus_type bus_in,
    input wire logic bit_mode_10_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic row_strobe_out,
    input wire logic data_valid_out,
    input wire logic [PIX_W-1:0] lane_word_out,
    input wire logic [LANES_MAX-1:0] lane_enable_out,
    input wire logic frame_start_out,
    input wire logic burst_done_out,
    input wire logic busy_out,
    input wire srcfg_synth_type synth_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic [7:0] vcnt_reg;
    // counter, since repetition counts cannot follow the parameter
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) vcnt_reg <= 8'h00;
        else vcnt_reg <= data_valid_out ? vcnt_reg + 8'h01 : 8'h00;
    end
    rd_quiet_a: assert property (!bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data not zero outside read");
    lane_write_a: assert property (bus_in.wr && bus_in.addr == ADR_LANES |=>
        lane_enable_out == 16'hffff >> (16 - (16 >> $past(bus_in.wdata[1:0]))))
        else $error("lane enables wrong after select write");
    idle_narrow_a: assert property (!data_valid_out && $stable(data_valid_out)
        && bit_mode_10_in && $stable(bit_mode_10_in) |-> lane_word_out[11:10] == 2'b00)
        else $error("idle word not narrowed in 10-bit mode");
    row_len_a: assert property ($fell(data_valid_out) |-> vcnt_reg == ROW_CYCLES)
        else $error("row valid length wrong");
    strobe_gap_a: assert property (row_strobe_out |=> (!row_strobe_out)[*4])
        else $error("row strobes too close");
    frame_start_a: assert property (frame_start_out |-> row_strobe_out && busy_out)
        else $error("frame start without row strobe or busy");
    burst_end_a: assert property (burst_done_out |-> !busy_out && $past(busy_out))
        else $error("burst done without busy falling");
    synth_mux_a: assert property (synth_out.use_internal ==
        (synth_out.mult_on && !synth_out.mult_bypass))
        else $error("internal clock use wrong");
    syn_write_a: assert property (bus_in.wr && bus_in.addr == ADR_SYN_ON |=>
        synth_out.mult_on == $past(bus_in.wdata[0]))
        else $error("multiplier enable not following write");
    bias_off_a: assert property (synth_out.rx_current_on == (synth_out.rx_bias != 4'h0))
        else $error("receiver current state wrong");
endmodule
bind srcfg_top srcfg_chk #(.ROW_CYCLES(ROW_CYCLES)) srcfg_chk_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus_in), .bit_mode_10_in(bit_mode_10_in),
    .rdata_out(rdata_out), .row_strobe_out(row_strobe_out), .data_valid_out(data_valid_out),
    .lane_word_out(lane_word_out), .lane_enable_out(lane_enable_out),
    .frame_start_out(frame_start_out), .burst_done_out(burst_done_out),
    .busy_out(busy_out), .synth_out(synth_out));

// [test_sensor_readout_config.sv]
// Purpose: self-checking bench of the readout configuration bank
// Assumes: ROW_CYCLES 4, register port answers one cycle after a read
// Notes: window base and pixel word held constant
`timescale 1ns/1ps
module test_sensor_readout_config
    import srcfg_pkg::*;
;
    logic clk_in = 1'b0;
    logic nrst_in;
    srcfg_bus_type bus;
    logic frame_req, internal_exp, bit10;
    logic [ROW_W-1:0] row_base;
    logic [PIX_W-1:0] pixel;
    logic [DATA_W-1:0] rdata_out;
    logic [ROW_W-1:0] row_addr_out;
    logic row_strobe_out, data_valid_out, frame_start_out, burst_done_out, busy_out;
    logic [PIX_W-1:0] lane_word_out;
    logic [LANES_MAX-1:0] lane_enable_out;
    srcfg_synth_type synth_out;
    int n_fail = 0;
    int checks = 0;
    logic [6:0] ra [18] = '{7'h01, 7'h02, 7'h23, 7'h24, 7'h25, 7'h26, 7'h46, 7'h47, 7'h48,
        7'h4a, 7'h4e, 7'h4f, 7'h52, 7'h71, 7'h72, 7'h73, 7'h74, 7'h00};
    logic [7:0] rv [18] = '{8'h40, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
        8'h08, 8'h55, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'hd9, 8'h00};

    always #12.5 clk_in = ~clk_in;

    srcfg_top #(.ROW_CYCLES(4)) srcfg_top_inst (
        .clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .frame_req_in(frame_req),
        .internal_exposure_in(internal_exp), .bit_mode_10_in(bit10), .row_base_in(row_base),
        .pixel_data_in(pixel), .rdata_out(rdata_out), .row_addr_out(row_addr_out),
        .row_strobe_out(row_strobe_out), .data_valid_out(data_valid_out),
        .lane_word_out(lane_word_out), .lane_enable_out(lane_enable_out),
        .frame_start_out(frame_start_out), .burst_done_out(burst_done_out),
        .busy_out(busy_out), .synth_out(synth_out));

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task wr(input logic [6:0] a, input logic [7:0] d);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk_in);
        bus.wr <= 1'b0;
        #1;
    endtask

    task rd_chk(input logic [6:0] a, input logic [7:0] e);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, rdata_out});
    endtask

    // one request; a second edge lands while busy and must be ignored
    task burst(input int nf, input int nr, input int step);
        int rows, starts, k, cyc;
        rows = 0;
        starts = 0;
        k = 0;
        frame_req <= 1'b1;
        for (cyc = 0; cyc < 400 && burst_done_out !== 1'b1; cyc++) begin
            @(posedge clk_in);
            #1;
            if (cyc == 6 || cyc == 14) frame_req <= 1'b0;
            if (cyc == 10) frame_req <= 1'b1;
            if (row_strobe_out === 1'b1) begin
                if (frame_start_out === 1'b1) begin
                    starts++;
                    k = 0;
                end
                chk("row_addr", 16'(10 + k * step), {5'h00, row_addr_out});
                k++;
                rows++;
            end
            if (data_valid_out === 1'b1) chk("lane_word", 16'h0123, {4'h0, lane_word_out});
        end
        frame_req <= 1'b0;
        // a loop that ran out of cycles shows no done pulse here
        chk("done", 16'h0001, {15'h0, burst_done_out});
        chk("frames", 16'(nf), 16'(starts));
        chk("rows", 16'(nf * nr), 16'(rows));
        repeat (20) @(posedge clk_in);
        #1;
        chk("busy", 16'h0000, {15'h0, busy_out});
    endtask

    task report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #500000;
        n_fail++;
        report_and_stop;
    end

    initial begin
        nrst_in = 1'b0;
        bus = '0;
        {frame_req, internal_exp, bit10} = 3'b000;
        row_base = 11'd10;
        pixel = 12'h123;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk("use_internal", 16'h1, {15'h0, synth_out.use_internal});
        for (int i = 0; i < 18; i++) rd_chk(ra[i], rv[i]);
        wr(7'h00, 8'hff);
        rd_chk(7'h00, 8'h00);
        wr(ADR_IDLE_HI, 8'hff);
        rd_chk(ADR_IDLE_HI, 8'h0f);
        wr(ADR_CLK_IN, 8'hff);
        rd_chk(ADR_CLK_IN, 8'h04);
        chk("ext_clk", 16'h1, {15'h0, synth_out.ext_clk_en});
        for (int i = 0; i < 4; i++) begin
            wr(ADR_LANES, 8'(i));
            chk("lanes", 16'hffff >> (16 - (16 >> i)), lane_enable_out);
        end
        wr(ADR_IDLE_LO, 8'hab);
        repeat (2) @(posedge clk_in);
        #1;
        chk("idle", 16'h0fab, {4'h0, lane_word_out});
        bit10 <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk("idle10", 16'h03ab, {4'h0, lane_word_out});
        bit10 <= 1'b0;
        wr(ADR_SYN_ON, 8'h00);
        chk("mult", 16'h0, {14'h0, synth_out.mult_on, synth_out.use_internal});
        wr(ADR_SYN_SKIP, 8'h01);
        chk("bypass", 16'h1, {15'h0, synth_out.mult_bypass});
        wr(ADR_RX_BIAS, 8'h00);
        chk("rx_on", 16'h0, {15'h0, synth_out.rx_current_on});
        wr(ADR_RX_BIAS, 8'h0f);
        chk("rx_bias", 16'h1f, {11'h0, synth_out.rx_current_on, synth_out.rx_bias});
        // band for a 20-30 MHz clock: range 0, out band 1, in band 0; before any frame
        wr(ADR_SYN_BAND, 8'h10);
        wr(ADR_SYN_IN, 8'h00);
        chk("band", 16'h2, 16'({synth_out.in_band, synth_out.out_band, synth_out.range}));
        wr(ADR_ROWS_LO, 8'h03);
        wr(ADR_ROWS_HI, 8'h00);
        wr(ADR_PLAIN_LO, 8'h01);
        wr(ADR_PAIR_LO, 8'h02);
        wr(ADR_FRAMES_LO, 8'h02);
        internal_exp <= 1'b1;
        burst(2, 3, 4);
        internal_exp <= 1'b0;
        burst(1, 3, 4);
        wr(ADR_PLAIN_LO, 8'h00);
        wr(ADR_PAIR_LO, 8'h04);
        burst(1, 3, 5);
        report_and_stop;
    end
endmodule
